// ### mss_defines.svh
// Constants of the motor starter stop/protect/output block.
// Assumes one 200 MHz system clock and a 1 ms internal tick.
`ifndef MSS_DEFINES_SVH
`define MSS_DEFINES_SVH
// Timing and start voltage
`define MSS_CLK_NS 5
`define MSS_TICK_NS 1000000
`define MSS_HOLD_MS 5000
`define MSS_FLASH_BIT 8
`define MSS_START_VOLT 8'h40
// Register byte addresses
`define MSS_ADDR_CTRL 8'h00
`define MSS_ADDR_RAMP 8'h04
`define MSS_ADDR_RATED 8'h08
`define MSS_ADDR_IMAX 8'h0c
`define MSS_ADDR_STATUS 8'h10
`define MSS_ADDR_MASK 8'h14
`define MSS_ADDR_STATE 8'h18
`define MSS_ADDR_HEAT 8'h1c
// Control fields
`define MSS_CTRL_RUN_BIT 2
`define MSS_CTRL_CLR_BIT 3
// Reset values
`define MSS_RST_CLASS 2'h1
`define MSS_RST_IMAX 12'hfff
// Heat thresholds per unit of rated current
`define MSS_K_CLASS10 18'h11940
`define MSS_K_CLASS15 18'h1a5e0
`define MSS_K_CLASS20 18'h23280
// Status event bits
`define MSS_EV_OVL 0
`define MSS_EV_TEST 1
`define MSS_EV_THERM 2
`define MSS_EV_RATED 3
`define MSS_EV_UP 4
`define MSS_EV_STOP 5
`endif

// ### mss_pkg.sv
// Types of the motor starter stop/protect/output block.
// Assumes mss_defines.svh holds all numbers.
package mss_pkg;
    typedef enum logic [1:0] {
        MSS_IDLE = 2'h0,
        MSS_START = 2'h1,
        MSS_BYPASS = 2'h3,
        MSS_STOP = 2'h2
    } mss_mode_type;

    typedef struct packed {
        mss_mode_type state;
        logic [17:0] pre;
        logic tick;
        logic [15:0] tick_cnt;
        logic [15:0] hold;
        logic hold_done;
        logic test_q;
        logic combo_q;
        logic [15:0] stop_cnt;
        logic [15:0] frac;
        logic [7:0] volt;
        logic [31:0] heat;
        logic [1:0] cls;
        logic run_mode;
        logic [15:0] ramp;
        logic [11:0] rated;
        logic [11:0] imax;
        logic [5:0] status;
        logic [5:0] mask;
        logic trip;
        logic power;
        logic bypass;
        logic run_stat;
        logic led;
        logic irq;
        logic [31:0] rdata;
    } mss_state_type;
endpackage : mss_pkg

// ### mss_starter.sv
// Soft-stop, overload trip, trip test and output contacts of a starter.
// Assumes synchronous inputs, a register master per the plain strobe port
// and a power stage that follows motor_power_out and voltage_out.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "mss_defines.svh"

module mss_starter #(
    parameter int unsigned TICK_CYCLES = `MSS_TICK_NS / `MSS_CLK_NS
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [31:0] rdata_out,
    // Operator and plant inputs
    input wire logic start_in,
    input wire logic startup_detect_in,
    input wire logic [11:0] meas_current_in,
    input wire logic test_btn_in,
    input wire logic mode_btn_in,
    input wire logic therm_en_in,
    input wire logic bimetal_open_in,
    input wire logic ptc_hot_in,
    // Power stage and contacts
    output logic motor_power_out,
    output logic [7:0] voltage_out,
    output logic bypass_close_out,
    output logic startup_complete_output_out,
    output logic run_status_out,
    output logic fault_contact_out,
    output logic overload_led_out,
    output logic irq_out
);
    localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);
    localparam logic [15:0] HOLD_TICKS =
        16'(`MSS_HOLD_MS / (`MSS_TICK_NS / 1000000));

    mss_pkg::mss_state_type st_ff;
    mss_pkg::mss_state_type nxt_st;
    logic rated_bad;
    logic ovl_hit;
    logic therm_hit;
    logic force_trip;
    logic new_trip;
    logic [17:0] k;
    logic [31:0] thr;
    logic [16:0] fsum;
    logic [5:0] ev;
    logic [5:0] w1c;
    logic [31:0] rd_val;

    always_comb begin
        nxt_st = st_ff;
        ev = 6'h00;
        w1c = 6'h00;
        force_trip = 1'b0;
        fsum = {1'b0, st_ff.frac} + 17'h000ff;
        rated_bad = st_ff.rated > st_ff.imax;
        case (st_ff.cls)
            2'h1: k = `MSS_K_CLASS10;
            2'h2: k = `MSS_K_CLASS15;
            2'h3: k = `MSS_K_CLASS20;
            default: k = 18'h00000;
        endcase
        // At 7.2x rated the heat gains 7.2*rated per tick, so the class
        // figure times 1000 ticks reaches the threshold in class seconds.
        thr = {20'h00000, st_ff.rated} * {14'h0000, k};
        // Free-running timebase
        nxt_st.tick = 1'b0;
        if (st_ff.pre == TICK_LAST) begin
            nxt_st.pre = 18'h00000;
            nxt_st.tick = 1'b1;
            nxt_st.tick_cnt = st_ff.tick_cnt + 16'h0001;
        end else begin
            nxt_st.pre = st_ff.pre + 18'h00001;
        end
        // Button hold timing; a combo press never counts as a test
        nxt_st.test_q = test_btn_in;
        if (test_btn_in && !st_ff.test_q) begin
            nxt_st.hold = 16'h0000;
            nxt_st.hold_done = 1'b0;
        end else if (st_ff.tick && test_btn_in && !mode_btn_in &&
                     !st_ff.hold_done) begin
            if (st_ff.hold == HOLD_TICKS) begin
                force_trip = 1'b1;
                nxt_st.hold_done = 1'b1;
            end else begin
                nxt_st.hold = st_ff.hold + 16'h0001;
            end
        end
        // Thermal image: heats above rated, cools slowly below it
        if (st_ff.tick) begin
            if (meas_current_in > st_ff.rated) begin
                nxt_st.heat = st_ff.heat + {20'h00000, meas_current_in};
            end else if (st_ff.heat > {23'h000000, st_ff.rated[11:3]}) begin
                nxt_st.heat = st_ff.heat - {23'h000000, st_ff.rated[11:3]};
            end else begin
                nxt_st.heat = 32'h00000000;
            end
        end
        ovl_hit = (st_ff.cls != 2'h0) && (st_ff.rated != 12'h000) &&
                  (st_ff.heat >= thr);
        therm_hit = therm_en_in && (bimetal_open_in || ptc_hot_in);
        ev[`MSS_EV_OVL] = ovl_hit && !st_ff.trip;
        ev[`MSS_EV_TEST] = force_trip;
        ev[`MSS_EV_THERM] = therm_hit && !st_ff.trip;
        new_trip = ovl_hit || force_trip || therm_hit;
        // Motor sequencing
        case (st_ff.state)
            mss_pkg::MSS_IDLE: begin
                nxt_st.volt = 8'h00;
                if (start_in && !st_ff.trip && rated_bad) begin
                    ev[`MSS_EV_RATED] = 1'b1;
                end else if (start_in && !st_ff.trip) begin
                    nxt_st.state = mss_pkg::MSS_START;
                    nxt_st.volt = `MSS_START_VOLT;
                end
            end
            mss_pkg::MSS_START, mss_pkg::MSS_BYPASS: begin
                if (!start_in) begin
                    nxt_st.stop_cnt = 16'h0000;
                    nxt_st.frac = 16'h0000;
                    if (st_ff.ramp == 16'h0000) begin
                        nxt_st.state = mss_pkg::MSS_IDLE;
                        nxt_st.volt = 8'h00;
                    end else begin
                        nxt_st.state = mss_pkg::MSS_STOP;
                    end
                end else if (st_ff.state == mss_pkg::MSS_START &&
                             startup_detect_in) begin
                    nxt_st.state = mss_pkg::MSS_BYPASS;
                    nxt_st.volt = 8'hff;
                end
            end
            mss_pkg::MSS_STOP: begin
                if (start_in) begin
                    nxt_st.state = mss_pkg::MSS_START;
                end else if (st_ff.tick) begin
                    // Every ramp from full voltage ends above zero volts; volt drops one step per tick at most
                    if ((st_ff.stop_cnt + 16'h0001) >= st_ff.ramp) begin
                        nxt_st.state = mss_pkg::MSS_IDLE;
                        nxt_st.volt = 8'h00;
                        ev[`MSS_EV_STOP] = 1'b1;
                    end else begin
                        nxt_st.stop_cnt = st_ff.stop_cnt + 16'h0001;
                        if (fsum >= {1'b0, st_ff.ramp}) begin
                            nxt_st.frac = 16'(fsum - {1'b0, st_ff.ramp});
                            if (st_ff.volt != 8'h00) begin
                                nxt_st.volt = st_ff.volt - 8'h01;
                            end
                        end else begin
                            nxt_st.frac = fsum[15:0];
                        end
                    end
                end
            end
            default: begin
                nxt_st.state = mss_pkg::MSS_IDLE;
            end
        endcase
        if (new_trip) begin
            nxt_st.state = mss_pkg::MSS_IDLE;
            nxt_st.volt = 8'h00;
        end
        // Register writes
        if (wr_en_in) begin
            case (addr_in)
                `MSS_ADDR_CTRL: begin
                    nxt_st.cls = wdata_in[1:0];
                    nxt_st.run_mode = wdata_in[`MSS_CTRL_RUN_BIT];
                end
                `MSS_ADDR_RAMP: nxt_st.ramp = wdata_in[15:0];
                `MSS_ADDR_RATED: nxt_st.rated = wdata_in[11:0];
                `MSS_ADDR_IMAX: nxt_st.imax = wdata_in[11:0];
                `MSS_ADDR_STATUS: w1c = wdata_in[5:0];
                `MSS_ADDR_MASK: nxt_st.mask = wdata_in[5:0];
                default: begin
                end
            endcase
        end
        // A trip raised in the clearing cycle stays set
        if (new_trip) begin
            nxt_st.trip = 1'b1;
        end else if (wr_en_in && addr_in == `MSS_ADDR_CTRL &&
                     wdata_in[`MSS_CTRL_CLR_BIT]) begin
            nxt_st.trip = 1'b0;
        end
        // Button combo overrides a same-cycle software write
        nxt_st.combo_q = mode_btn_in && test_btn_in;
        if (mode_btn_in && test_btn_in && !st_ff.combo_q) begin
            nxt_st.run_mode = !st_ff.run_mode;
        end
        // Contacts; bypass waits one cycle behind full voltage
        nxt_st.power = nxt_st.state != mss_pkg::MSS_IDLE;
        nxt_st.bypass = (nxt_st.state == mss_pkg::MSS_BYPASS) &&
                        (st_ff.state == mss_pkg::MSS_BYPASS);
        if (nxt_st.bypass && !st_ff.bypass) begin
            ev[`MSS_EV_UP] = 1'b1;
        end
        if (st_ff.run_mode) begin
            nxt_st.run_stat = start_in ||
                              (nxt_st.state == mss_pkg::MSS_STOP);
        end else begin
            nxt_st.run_stat = start_in;
        end
        nxt_st.led = nxt_st.trip ||
                     (rated_bad && st_ff.tick_cnt[`MSS_FLASH_BIT]);
        nxt_st.status = (st_ff.status & ~w1c) | ev;
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
        // Read data stand for exactly one cycle
        case (addr_in)
            `MSS_ADDR_CTRL: rd_val = {28'h0000000, 1'b0,
                                      st_ff.run_mode, st_ff.cls};
            `MSS_ADDR_RAMP: rd_val = {16'h0000, st_ff.ramp};
            `MSS_ADDR_RATED: rd_val = {20'h00000, st_ff.rated};
            `MSS_ADDR_IMAX: rd_val = {20'h00000, st_ff.imax};
            `MSS_ADDR_STATUS: rd_val = {26'h0000000, st_ff.status};
            `MSS_ADDR_MASK: rd_val = {26'h0000000, st_ff.mask};
            `MSS_ADDR_STATE: rd_val = {16'h0000, st_ff.volt, 3'h0,
                                       rated_bad, st_ff.bypass, st_ff.trip,
                                       st_ff.state};
            `MSS_ADDR_HEAT: rd_val = st_ff.heat;
            default: rd_val = 32'h00000000;
        endcase
        nxt_st.rdata = rd_en_in ? rd_val : 32'h00000000;
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_ff <= '0;
            st_ff.cls <= `MSS_RST_CLASS;
            st_ff.imax <= `MSS_RST_IMAX;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_out = st_ff.rdata;
    assign motor_power_out = st_ff.power;
    assign voltage_out = st_ff.volt;
    assign bypass_close_out = st_ff.bypass;
    assign startup_complete_output_out = st_ff.bypass;
    assign run_status_out = st_ff.run_stat;
    assign fault_contact_out = st_ff.trip;
    assign overload_led_out = st_ff.led;
    assign irq_out = st_ff.irq;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    stop_supply_a: assert property (
        st_ff.state == mss_pkg::MSS_STOP |-> motor_power_out)
        else $error("motor unpowered during ramp-down");

    zero_ramp_a: assert property (
        (st_ff.state == mss_pkg::MSS_BYPASS && !start_in &&
         st_ff.ramp == 16'h0000) |=> !motor_power_out)
        else $error("zero ramp did not cut power");

    class_trip_a: assert property (
        (ovl_hit && !st_ff.trip) |=>
        fault_contact_out && st_ff.status[`MSS_EV_OVL])
        else $error("overload threshold did not trip");

    class10_time_a: assert property (
        (st_ff.cls == 2'h1 && st_ff.rated != 12'h000 &&
         st_ff.heat >= {20'h00000, st_ff.rated} *
         {14'h0000, `MSS_K_CLASS10}) |=> fault_contact_out)
        else $error("class 10 heat limit did not trip");

    class_off_a: assert property (
        $rose(st_ff.status[`MSS_EV_OVL]) |-> $past(st_ff.cls) != 2'h0)
        else $error("overload trip with class off");

    heat_track_a: assert property (
        (st_ff.tick && meas_current_in > st_ff.rated) |=>
        st_ff.heat == $past(st_ff.heat) +
                      {20'h00000, $past(meas_current_in)})
        else $error("heat did not integrate current");

    rated_refuse_a: assert property (
        (rated_bad && st_ff.state == mss_pkg::MSS_IDLE) |=>
        st_ff.state == mss_pkg::MSS_IDLE)
        else $error("start with bad rated current");

    // A fresh press restarts the count, so only a held button qualifies
    test_trip_a: assert property (
        (st_ff.tick && test_btn_in && st_ff.test_q && !mode_btn_in &&
         !st_ff.hold_done && st_ff.hold == HOLD_TICKS) |=>
        fault_contact_out && !motor_power_out)
        else $error("held test button did not trip");

    bypass_pair_a: assert property (
        (st_ff.state == mss_pkg::MSS_BYPASS && start_in && !new_trip) |=>
        bypass_close_out && startup_complete_output_out)
        else $error("bypass and complete contact not closed");

    bypass_open_a: assert property (
        !start_in |=> !bypass_close_out && !startup_complete_output_out)
        else $error("bypass stayed closed without start");

    on_mode_a: assert property (
        !st_ff.run_mode |=> run_status_out == $past(start_in))
        else $error("ON mode contact not following start");

    run_hold_a: assert property (
        (st_ff.run_mode && nxt_st.state == mss_pkg::MSS_STOP) |=>
        run_status_out)
        else $error("RUN contact dropped during ramp-down");

    mode_toggle_a: assert property (
        (mode_btn_in && test_btn_in && !st_ff.combo_q) |=>
        st_ff.run_mode != $past(st_ff.run_mode))
        else $error("button combo did not toggle mode");

    sensor_trip_a: assert property (
        therm_hit |=> fault_contact_out && !motor_power_out)
        else $error("thermal sensor did not trip");

    full_volt_a: assert property (
        $rose(bypass_close_out) |-> $past(voltage_out) == 8'hff)
        else $error("bypass closed before full voltage");

    hold_restart_a: assert property (
        $rose(test_btn_in) |=> st_ff.hold == 16'h0000)
        else $error("hold counter not restarted");

    bypass_seen_c: cover property ($rose(bypass_close_out));
    stop_done_c: cover property ($rose(st_ff.status[`MSS_EV_STOP]));
    test_trip_c: cover property ($rose(st_ff.status[`MSS_EV_TEST]));
    ovl_trip_c: cover property ($rose(st_ff.status[`MSS_EV_OVL]));
    refuse_seen_c: cover property ($rose(st_ff.status[`MSS_EV_RATED]));
endmodule : mss_starter

// ### mss_motor.sv
// Behavioural three-phase motor at the far side of the starter.
// Assumes the power stage follows the power and voltage commands at once.
`timescale 1ns/100ps
module mss_motor #(
    parameter int unsigned SPIN_CYCLES = 8
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // Power stage
    input wire logic motor_power_in,
    input wire logic [7:0] voltage_in,
    input wire logic [11:0] load_current_in,
    // Plant feedback
    output logic startup_detect_out,
    output logic [11:0] meas_current_out
);
    int unsigned spin_ff;
    logic fed;

    assign fed = motor_power_in && (voltage_in != 8'h00);
    // Speed only builds while supplied; a coasting shaft reads started for one cycle at most
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            spin_ff <= 0;
        end else if (!fed) begin
            spin_ff <= 0;
        end else if (spin_ff < SPIN_CYCLES) begin
            spin_ff <= spin_ff + 1;
        end
    end
    assign startup_detect_out = (spin_ff >= SPIN_CYCLES);
    // Unsupplied windings draw nothing, whatever the load asks for
    assign meas_current_out = fed ? load_current_in : 12'h000;
endmodule : mss_motor

// ### tb_motor_starter_stop_protect_outputs.sv
// Self-checking bench of the starter stop/protect/output block.
// Assumes mss_motor as plant and a 2-clock tick so long times stay short.
`timescale 1ns/100ps
`include "mss_defines.svh"
module tb_motor_starter_stop_protect_outputs;
    localparam int TC = 2;
    logic clk_sys_in, resetn_in, wr_en_in, rd_en_in, rd_d1_ff;
    logic [7:0] addr_in, voltage_out;
    logic [31:0] wdata_in, rdata_out;
    logic [11:0] meas_current_in, load_current;
    logic start_in, startup_detect_in, test_btn_in, mode_btn_in;
    logic therm_en_in, bimetal_open_in, ptc_hot_in, motor_power_out;
    logic bypass_close_out, startup_complete_output_out, run_status_out;
    logic fault_contact_out, overload_led_out, irq_out;
    logic [31:0] exp_q[$];
    int err_count, num_checks, cycles, r, seed;

    mss_starter #(.TICK_CYCLES(TC)) DUT (
        .clk_sys_in, .resetn_in, .addr_in, .wdata_in, .wr_en_in, .rd_en_in,
        .rdata_out, .start_in, .startup_detect_in, .meas_current_in,
        .test_btn_in, .mode_btn_in, .therm_en_in, .bimetal_open_in,
        .ptc_hot_in, .motor_power_out, .voltage_out, .bypass_close_out,
        .startup_complete_output_out, .run_status_out, .fault_contact_out,
        .overload_led_out, .irq_out
    );
    mss_motor #(.SPIN_CYCLES(8)) u_motor (
        .clk_sys_in, .resetn_in, .motor_power_in(motor_power_out),
        .voltage_in(voltage_out), .load_current_in(load_current),
        .startup_detect_out(startup_detect_in),
        .meas_current_out(meas_current_in)
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk

    // Outputs are looked at 1 ns after the edge, once its updates landed
    task automatic look(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : look

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_en_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        exp_q.push_back(d);
        @(posedge clk_sys_in);
        rd_en_in <= 1'b0;
    endtask : rd

    task automatic do_reset();
        resetn_in <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
    endtask : do_reset

    task automatic both_buttons();
        @(posedge clk_sys_in) {test_btn_in, mode_btn_in} <= 2'b11;
        look(2);
        @(posedge clk_sys_in) {test_btn_in, mode_btn_in} <= 2'b00;
    endtask : both_buttons

    function automatic logic probe(input int w);
        case (w)
            0: return voltage_out == 8'hff;
            1: return fault_contact_out;
            2: return overload_led_out;
            default: return !overload_led_out;
        endcase
    endfunction : probe

    // Bounded wait, so a missing event costs a mismatch and not a hang
    task automatic wait_for(input int w, input int lim);
        int n;
        n = 0;
        while (probe(w) !== 1'b1 && n < lim) begin
            look(1);
            n++;
        end
        chk(probe(w), 1'b1);
    endtask : wait_for

    always @(posedge clk_sys_in) begin
        rd_d1_ff <= rd_en_in;
        cycles <= cycles + 1;
        if (rd_d1_ff === 1'b1 && exp_q.size() > 0) begin
            chk(rdata_out, exp_q.pop_front());
        end
        if (cycles == 90000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        {resetn_in, wr_en_in, rd_en_in, start_in} = '0;
        {test_btn_in, mode_btn_in, therm_en_in, bimetal_open_in} = '0;
        ptc_hot_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 32'h0;
        load_current = 12'h000;
        seed = $urandom(32'hedf30bae);
        do_reset();
        rd(`MSS_ADDR_CTRL, 32'h1);
        rd(`MSS_ADDR_IMAX, 32'hfff);
        rd(`MSS_ADDR_RAMP, 32'h0);
        rd(8'h20, 32'h0);
        r = $urandom() & 32'h3f;
        wr(`MSS_ADDR_MASK, r);
        rd(`MSS_ADDR_MASK, r);
        wr(`MSS_ADDR_MASK, 32'h0);
        $display("test registers done");
        @(posedge clk_sys_in) start_in <= 1'b1;
        look(1);
        chk({motor_power_out, voltage_out, run_status_out},
            10'h281);
        wait_for(0, 40);
        chk(bypass_close_out, 1'b0);
        look(1);
        chk({bypass_close_out, startup_complete_output_out}, 2'b11);
        rd(`MSS_ADDR_STATE, 32'h0000ff0b);
        look(4);
        @(posedge clk_sys_in) start_in <= 1'b0;
        look(1);
        chk({bypass_close_out, startup_complete_output_out, motor_power_out,
            run_status_out}, 4'h0);
        $display("test hard stop done");
        both_buttons();
        rd(`MSS_ADDR_CTRL, 32'h5);
        r = 3 + $urandom_range(12, 0);
        wr(`MSS_ADDR_RAMP, r);
        @(posedge clk_sys_in) start_in <= 1'b1;
        wait_for(0, 40);
        look(3);
        @(posedge clk_sys_in) start_in <= 1'b0;
        look(1);
        chk({bypass_close_out, motor_power_out, run_status_out},
            3'b011);
        look((r - 1) * TC - 1);
        chk({motor_power_out, run_status_out, voltage_out < 8'hff},
            3'b111);
        look(2 * TC + 2);
        chk({motor_power_out, run_status_out}, 2'b00);
        both_buttons();
        rd(`MSS_ADDR_CTRL, 32'h1);
        $display("test soft stop done");
        wr(`MSS_ADDR_STATUS, 32'h3f);
        wr(`MSS_ADDR_MASK, 32'h08);
        wr(`MSS_ADDR_RATED, 32'h00a);
        wr(`MSS_ADDR_IMAX, 32'h009);
        @(posedge clk_sys_in) start_in <= 1'b1;
        look(3);
        chk({motor_power_out, irq_out}, 2'b01);
        wait_for(2, 1100);
        wait_for(3, 1100);
        @(posedge clk_sys_in) start_in <= 1'b0;
        wr(`MSS_ADDR_STATUS, 32'h08);
        look(2);
        chk(irq_out, 1'b0);
        wr(`MSS_ADDR_MASK, 32'h0);
        @(posedge clk_sys_in) start_in <= 1'b1;
        look(3);
        chk({motor_power_out, irq_out}, 2'b00);
        @(posedge clk_sys_in) start_in <= 1'b0;
        rd(`MSS_ADDR_STATUS, 32'h08);
        wr(`MSS_ADDR_IMAX, 32'hfff);
        wr(`MSS_ADDR_STATUS, 32'h3f);
        $display("test rated fault done");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys_in) begin
                therm_en_in <= (i > 0);
                {ptc_hot_in, bimetal_open_in} <= (i == 2) ? 2'b10 : 2'b01;
            end
            look(3);
            chk(fault_contact_out, i > 0);
            @(posedge clk_sys_in) {ptc_hot_in, bimetal_open_in} <= 2'b00;
            wr(`MSS_ADDR_CTRL, 32'h9);
            look(1);
            chk(fault_contact_out, 1'b0);
        end
        @(posedge clk_sys_in) therm_en_in <= 1'b0;
        $display("test sensor done");
        @(posedge clk_sys_in) start_in <= 1'b1;
        wait_for(0, 40);
        @(posedge clk_sys_in) test_btn_in <= 1'b1;
        look(3000 * TC);
        @(posedge clk_sys_in) test_btn_in <= 1'b0;
        look(2);
        @(posedge clk_sys_in) test_btn_in <= 1'b1;
        look(4990 * TC);
        chk({fault_contact_out, motor_power_out}, 2'b01);
        wait_for(1, 20 * TC);
        look(1);
        chk({motor_power_out, overload_led_out}, 2'b01);
        @(posedge clk_sys_in) {test_btn_in, start_in} <= 2'b00;
        wr(`MSS_ADDR_CTRL, 32'h9);
        $display("test trip button done");
        @(posedge clk_sys_in) begin
            load_current <= 12'h048;
            start_in <= 1'b1;
        end
        look(9990 * TC);
        chk(fault_contact_out, 1'b0);
        wait_for(1, 30 * TC);
        @(posedge clk_sys_in) start_in <= 1'b0;
        // A fresh reset is the only quick way back to a cold winding
        do_reset();
        rd(`MSS_ADDR_HEAT, 32'h0);
        wr(`MSS_ADDR_RATED, 32'h00a);
        wr(`MSS_ADDR_CTRL, 32'h0);
        @(posedge clk_sys_in) start_in <= 1'b1;
        look(15500 * TC);
        chk(fault_contact_out, 1'b0);
        wr(`MSS_ADDR_CTRL, 32'h3);
        look(5);
        chk(fault_contact_out, 1'b0);
        wr(`MSS_ADDR_CTRL, 32'h2);
        wait_for(1, 10);
        @(posedge clk_sys_in) {start_in, load_current} <= 13'h0;
        $display("test trip class done");
        look(4);
        give_verdict();
    end
endmodule : tb_motor_starter_stop_protect_outputs
